/* File: hw/i2c_slave_engine.sv */
// Slave-side bus protocol engine with register port.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module i2c_slave_engine (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus.
  i2c_bus_if.device bus,
  // Register port.
  input wire logic [3:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [15:0] regRdata,
  // Event output.
  output logic eventIrq
);
  import i2c_engine_pkg::*;

  // ****************************************
  // Pin filtering
  // ****************************************
  logic scl, sda, sclRise, sclFall, sdaRise, sdaFall;
  pin_filter sclFilt (.clk(clk), .rst_n(rst_n), .pinIn(bus.scl), .level(scl), .rise(sclRise), .fall(sclFall));
  pin_filter sdaFilt (.clk(clk), .rst_n(rst_n), .pinIn(bus.sda), .level(sda), .rise(sdaRise), .fall(sdaFall));

  // ****************************************
  // Registers
  // ****************************************
  logic [9:0] ctrl_q;
  logic [7:0] slvAddr_q, rxBuf_q, txBuf_q, shift_q;
  logic [3:0] bitCnt_q;
  logic [4:0] holdCnt_q;
  logic [15:0] rdata_q;
  logic active_q, sclLowSeen_q, addressed_q, firstByte_q, rw_q, hiMatched_q, prior_q;
  logic bufFull_q, ovf_q, ackRx_q, ackTime_q, coll_q, startSeen_q, stopSeen_q, event_q;
  logic sdaDrvLow_q, pendLow_q, pendPend_q;

  wire en = ctrl_q[CtrlEnBit];
  wire [2:0] modeBits = ctrl_q[CtrlModeLo +: 3];
  wire modeOn = en && (modeBits != ModeOff);
  wire tenBit = (modeBits == Mode10) || (modeBits == Mode10Irq);
  wire irqMode = (modeBits == Mode7Irq) || (modeBits == Mode10Irq);
  wire holdEn = ctrl_q[CtrlAddrHoldBit] || ctrl_q[CtrlDataHoldBit];

  wire startCond = modeOn && scl && sdaFall;
  // Stop needs an SCL low since start.
  wire stopCond = modeOn && scl && sdaRise && sclLowSeen_q;
  // Receiver samples data at SCL rise.
  wire [7:0] shiftNext = {shift_q[6:0], sda};
  wire dataSample = modeOn && active_q && sclRise && (bitCnt_q < 4'(ByteBits));
  wire ackSample = modeOn && active_q && sclRise && (bitCnt_q == 4'(AckSlot));
  wire eighthFall = modeOn && active_q && sclFall && (bitCnt_q == 4'(AckSlot));
  wire ninthFall = modeOn && active_q && sclFall && (bitCnt_q == 4'(AckSlot + 1));

  wire hiMatch = (shift_q[7:1] == 7'(hiAddrByte(slvAddr_q[2:1], 1'b0) >> 1));
  wire addrMatch7 = (shift_q[7:1] == slvAddr_q[7:1]);
  wire rxRead = shift_q[0];
  // Ten-bit read only after a prior full match.
  wire readOk10 = hiMatch && rxRead && prior_q;
  wire firstMatch = tenBit ? (hiMatch && (!rxRead || prior_q)) : addrMatch7;
  wire nowAddressed = firstByte_q ? firstMatch : (hiMatched_q ? (shift_q == slvAddr_q) : addressed_q);
  wire overflow = bufFull_q || ovf_q;
  wire ackLow = !overflow && (holdEn ? !ctrl_q[CtrlAckValBit] : 1'b1);
  // Start and stop events always in irq modes, else only when enabled.
  wire condIrqStart = irqMode || ctrl_q[CtrlStartIeBit];
  wire condIrqStop = irqMode || ctrl_q[CtrlStopIeBit];
  wire [4:0] holdLen = ctrl_q[CtrlHoldSelBit] ? 5'(HoldLongCycles) : 5'(HoldShortCycles);

  // ****************************************
  // Bus sequencing
  // ****************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      active_q <= 1'b0;
      sclLowSeen_q <= 1'b0;
      bitCnt_q <= 4'h0;
      shift_q <= 8'h00;
      addressed_q <= 1'b0;
      firstByte_q <= 1'b0;
      hiMatched_q <= 1'b0;
      rw_q <= 1'b0;
      prior_q <= 1'b0;
      ackRx_q <= 1'b0;
      sdaDrvLow_q <= 1'b0;
      pendLow_q <= 1'b0;
      pendPend_q <= 1'b0;
      holdCnt_q <= 5'h00;
    end else if (!modeOn || stopCond) begin
      // Stop, or leaving the mode, ends the prior match.
      active_q <= 1'b0;
      addressed_q <= 1'b0;
      prior_q <= 1'b0;
      sdaDrvLow_q <= 1'b0;
      pendPend_q <= 1'b0;
      bitCnt_q <= 4'h0;
    end else if (startCond) begin
      // Start or restart resets slave logic.
      active_q <= 1'b1;
      sclLowSeen_q <= 1'b0;
      bitCnt_q <= 4'h0;
      firstByte_q <= 1'b1;
      addressed_q <= 1'b0;
      hiMatched_q <= 1'b0;
      sdaDrvLow_q <= 1'b0;
      pendPend_q <= 1'b0;
    end else begin
      if (!scl) begin
        sclLowSeen_q <= 1'b1;
      end
      if (dataSample) begin
        // Shift in most significant bit first.
        shift_q <= shiftNext;
        bitCnt_q <= bitCnt_q + 4'h1;
      end
      if (ackSample) begin
        ackRx_q <= sda;
        bitCnt_q <= bitCnt_q + 4'h1;
      end
      if (eighthFall) begin
        firstByte_q <= 1'b0;
        addressed_q <= nowAddressed;
        if (firstByte_q) begin
          rw_q <= rxRead;
          hiMatched_q <= tenBit && hiMatch && !rxRead;
          // High address clears prior flag unless read.
          if (tenBit && !readOk10) begin
            prior_q <= 1'b0;
          end
        end else if (hiMatched_q) begin
          hiMatched_q <= 1'b0;
          prior_q <= (shift_q == slvAddr_q);
        end
        pendLow_q <= nowAddressed && (rw_q == 1'b0 || firstByte_q) && ackLow;
        pendPend_q <= 1'b1;
        holdCnt_q <= holdLen;
      end
      if (ninthFall) begin
        bitCnt_q <= 4'h0;
        pendLow_q <= 1'b0;
        pendPend_q <= 1'b1;
        holdCnt_q <= holdLen;
      end
      if (pendPend_q) begin
        if (holdCnt_q <= 5'h1) begin
          sdaDrvLow_q <= pendLow_q;
          pendPend_q <= 1'b0;
        end else begin
          holdCnt_q <= holdCnt_q - 5'h1;
        end
      end
    end
  end

  // ****************************************
  // Status flags
  // ****************************************
  wire rdData = regRd && (regAddr == RegDataAddr);
  wire wrStat = regWr && (regAddr == RegStatAddr);
  // Idle when no master and both lines high.
  wire busIdle = !active_q && scl && sda;
  wire collNow = modeOn && !sdaDrvLow_q && sclRise && !sda && addressed_q && rw_q && !firstByte_q
                 && (bitCnt_q < 4'(ByteBits)) && txBuf_q[3'(7 - bitCnt_q[2:0])];
  wire ackTimeSet = eighthFall && nowAddressed && holdEn;
  wire rxStore = eighthFall && nowAddressed && !(firstByte_q ? rxRead : rw_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bufFull_q <= 1'b0;
      ovf_q <= 1'b0;
      ackTime_q <= 1'b0;
      coll_q <= 1'b0;
      startSeen_q <= 1'b0;
      stopSeen_q <= 1'b0;
      event_q <= 1'b0;
      rxBuf_q <= 8'h00;
    end else begin
      if (rxStore && !overflow) begin
        rxBuf_q <= shift_q;
      end
      bufFull_q <= (rxStore && !overflow) || (bufFull_q && !rdData);
      ovf_q <= (rxStore && overflow) || (ovf_q && !(wrStat && regWdata[StOvfBit]));
      ackTime_q <= ackTimeSet || (ackTime_q && !ninthFall && !startCond && !stopCond);
      coll_q <= collNow || (coll_q && !(wrStat && regWdata[StCollBit]));
      startSeen_q <= startCond || (startSeen_q && !stopCond);
      stopSeen_q <= stopCond || (stopSeen_q && !startCond);
      event_q <= (startCond && condIrqStart) || (stopCond && condIrqStop) || (eighthFall && nowAddressed)
                 || (event_q && !(wrStat && regWdata[StEventBit]));
    end
  end

  // ****************************************
  // Register port
  // ****************************************
  wire [15:0] statWord = {5'h00, rw_q, event_q, prior_q, ackTime_q, ovf_q, bufFull_q, ackRx_q, coll_q,
                          stopSeen_q, startSeen_q, !busIdle};

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= CtrlReset;
      slvAddr_q <= 8'h00;
      txBuf_q <= 8'h00;
      rdata_q <= 16'h0000;
    end else begin
      if (regWr && regAddr == RegCtrlAddr) begin
        ctrl_q <= regWdata[9:0];
      end
      if (regWr && regAddr == RegAddrAddr) begin
        slvAddr_q <= regWdata[7:0];
      end
      if (regWr && regAddr == RegDataAddr) begin
        txBuf_q <= regWdata[7:0];
      end
      if (regRd) begin
        case (regAddr)
          RegCtrlAddr: rdata_q <= {6'h00, ctrl_q};
          RegStatAddr: rdata_q <= statWord;
          RegDataAddr: rdata_q <= {8'h00, rxBuf_q};
          RegAddrAddr: rdata_q <= {8'h00, slvAddr_q};
          default: rdata_q <= 16'h0000;
        endcase
      end
    end
  end

  assign regRdata = rdata_q;
  assign eventIrq = event_q;
  // Open drain: output zero, enable pulls low.
  assign bus.sclOutDev = 1'b0;
  assign bus.sdaOutDev = 1'b0;
  assign bus.sclOeDev = 1'b0;
  // Collision at start is not raised by a slave driver.
  assign bus.sdaOeDev = modeOn && sdaDrvLow_q;
endmodule // i2c_slave_engine

/* File: hw/i2c_engine_pkg.sv */
// Shared constants and types for the serial port bus engine and its bus partner.
package i2c_engine_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int ClkPeriodNs = 20;
  localparam int HoldLongNs = 300;
  localparam int HoldLongCycles = (HoldLongNs + ClkPeriodNs - 1) / ClkPeriodNs;
  localparam int HoldShortCycles = 1;
  localparam int FilterDepth = 3;
  localparam int ByteBits = 8;
  localparam int AckSlot = 8;
  localparam int HalfBitDefault = 4;

  // ****************************************
  // Register addresses of the engine (word offsets)
  // ****************************************
  localparam logic [3:0] RegCtrlAddr = 4'h0;
  localparam logic [3:0] RegStatAddr = 4'h1;
  localparam logic [3:0] RegDataAddr = 4'h2;
  localparam logic [3:0] RegAddrAddr = 4'h3;
  localparam logic [3:0] RegAddrHiAddr = 4'h4;
  localparam logic [3:0] RegCmdAddr = 4'h5;
  localparam logic [3:0] RegPartnerAddr = 4'h6;

  // Control bit positions.
  localparam int CtrlEnBit = 0;
  localparam int CtrlModeLo = 1;
  localparam int CtrlHoldSelBit = 4;
  localparam int CtrlAddrHoldBit = 5;
  localparam int CtrlDataHoldBit = 6;
  localparam int CtrlAckValBit = 7;
  localparam int CtrlStartIeBit = 8;
  localparam int CtrlStopIeBit = 9;
  localparam logic [9:0] CtrlReset = 10'h000;

  // Status bit positions.
  localparam int StBusyBit = 0;
  localparam int StStartBit = 1;
  localparam int StStopBit = 2;
  localparam int StCollBit = 3;
  localparam int StAckRxBit = 4;
  localparam int StBufFullBit = 5;
  localparam int StOvfBit = 6;
  localparam int StAckTimeBit = 7;
  localparam int StPriorBit = 8;
  localparam int StEventBit = 9;
  localparam int StRwBit = 10;

  // Partner command codes.
  typedef enum logic [1:0] {
    CmdNone = 2'b00,
    CmdStart = 2'b01,
    CmdByte = 2'b10,
    CmdStop = 2'b11
  } cmd_t;

  // Engine slave modes.
  typedef enum logic [2:0] {
    ModeOff = 3'b000,
    Mode7 = 3'b001,
    Mode10 = 3'b010,
    Mode7Irq = 3'b011,
    Mode10Irq = 3'b100
  } mode_t;

  function automatic logic [7:0] hiAddrByte(input logic [1:0] a98, input logic rw);
    hiAddrByte = {5'h1e, a98, rw};
  endfunction

endpackage

/* File: hw/i2c_bus_if.sv */
// Open-drain two-wire bus joining the engine and its partner.
`timescale 1ns/10ps
interface i2c_bus_if;
  logic sclOeDev;
  logic sdaOeDev;
  logic sclOePar;
  logic sdaOePar;
  logic sclOutDev;
  logic sdaOutDev;
  logic sclOutPar;
  logic sdaOutPar;
  wire scl = !((sclOeDev && !sclOutDev) || (sclOePar && !sclOutPar));
  wire sda = !((sdaOeDev && !sdaOutDev) || (sdaOePar && !sdaOutPar));
  modport device (input scl, input sda, output sclOeDev, output sdaOeDev, output sclOutDev, output sdaOutDev);
  modport partner (input scl, input sda, output sclOePar, output sdaOePar, output sclOutPar, output sdaOutPar);
endinterface

/* File: hw/pin_filter.sv */
// Three-stage synchroniser with agreement filter for one bus pin.
`timescale 1ns/10ps
module pin_filter (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Pin and filtered level.
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  import i2c_engine_pkg::*;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic level_q;
  wire agree = (s2_q == s3_q);
  wire level_d = agree ? s3_q : level_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      level_q <= 1'b1;
    end else begin
      s1_q <= pinIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;
  assign rise = level_d && !level_q;
  assign fall = !level_d && level_q;
endmodule // pin_filter

/* File: hw/i2c_bus_master.sv */
// Bus partner: a simple master that issues start, byte and stop.
`timescale 1ns/10ps
module i2c_bus_master #(
  parameter int HalfBit = i2c_engine_pkg::HalfBitDefault
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus.
  i2c_bus_if.partner bus,
  // Command port.
  input wire logic [1:0] cmd,
  input wire logic [7:0] txByte,
  input wire logic cmdValid,
  output logic cmdReady,
  output logic [7:0] rxByte,
  output logic ackSeen
);
  import i2c_engine_pkg::*;

  if (HalfBit < 2 || HalfBit > 255) begin : g_bad_half_bit
    $error("HalfBit out of range");
  end

  typedef enum logic [1:0] {
    StIdle = 2'b00,
    StStart = 2'b01,
    StBits = 2'b10,
    StStop = 2'b11
  } state_t;

  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic sdaIn_q;
  state_t state_q;
  logic [7:0] div_q;
  logic [1:0] phase_q;
  logic [3:0] bit_q;
  logic [7:0] sh_q;
  logic [7:0] rx_q;
  logic ack_q;
  logic sclLow_q;
  logic sdaLow_q;

  wire tick = (div_q == 8'(HalfBit - 1));
  // SDA is sampled with a filtered copy on the SCL rise.
  wire sdaAgree = (s2_q == s3_q);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sdaIn_q <= 1'b1;
      state_q <= StIdle;
      div_q <= 8'h00;
      phase_q <= 2'b00;
      bit_q <= 4'h0;
      sh_q <= 8'h00;
      rx_q <= 8'h00;
      ack_q <= 1'b1;
      sclLow_q <= 1'b0;
      sdaLow_q <= 1'b0;
    end else begin
      s1_q <= bus.sda;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (sdaAgree) begin
        sdaIn_q <= s3_q;
      end
      div_q <= (state_q == StIdle || tick) ? 8'h00 : div_q + 8'h01;
      case (state_q)
        StIdle: begin
          phase_q <= 2'b00;
          if (cmdValid && cmd == CmdStart) begin
            state_q <= StStart;
          end else if (cmdValid && cmd == CmdByte) begin
            sh_q <= txByte;
            bit_q <= 4'h0;
            state_q <= StBits;
          end else if (cmdValid && cmd == CmdStop) begin
            state_q <= StStop;
          end
        end
        StStart: if (tick) begin
          phase_q <= phase_q + 2'b01;
          case (phase_q)
            2'b00: begin
              sdaLow_q <= 1'b0;
              sclLow_q <= 1'b0;
            end
            2'b01: sdaLow_q <= 1'b1;
            default: begin
              sclLow_q <= 1'b1;
              state_q <= StIdle;
            end
          endcase
        end
        StBits: if (tick) begin
          phase_q <= phase_q + 2'b01;
          case (phase_q)
            2'b00: sdaLow_q <= (bit_q < 4'h8) ? !sh_q[7] : 1'b0;
            2'b01: begin
              sclLow_q <= 1'b0;
              if (bit_q < 4'h8) begin
                rx_q <= {rx_q[6:0], sdaIn_q};
              end else begin
                ack_q <= sdaIn_q;
              end
            end
            default: begin
              sclLow_q <= 1'b1;
              phase_q <= 2'b00;
              sh_q <= {sh_q[6:0], 1'b0};
              bit_q <= bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                sdaLow_q <= 1'b0;
                state_q <= StIdle;
              end
            end
          endcase
        end
        StStop: if (tick) begin
          phase_q <= phase_q + 2'b01;
          case (phase_q)
            2'b00: sdaLow_q <= 1'b1;
            2'b01: sclLow_q <= 1'b0;
            default: begin
              sdaLow_q <= 1'b0;
              state_q <= StIdle;
            end
          endcase
        end
        default: state_q <= StIdle;
      endcase
    end
  end

  assign cmdReady = (state_q == StIdle);
  assign rxByte = rx_q;
  assign ackSeen = !ack_q;
  assign bus.sclOutPar = 1'b0;
  assign bus.sdaOutPar = 1'b0;
  assign bus.sclOePar = sclLow_q;
  assign bus.sdaOePar = sdaLow_q;
endmodule // i2c_bus_master

/* File: verif/i2c_bus_props.sv */
// Concurrent checks on the two-wire bus between the engine and the master.
`timescale 1ns/10ps
module i2c_bus_props (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst_n,
  // Bus wires and engine drivers.
  input wire logic scl,
  input wire logic sda,
  input wire logic sclOeDev,
  input wire logic sdaOeDev,
  input wire logic sclOutDev,
  input wire logic sdaOutDev
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // ****************************************
  // Engine drive checks
  // ****************************************
  a_scl_left_free: assert property (!sclOeDev)
    else $error("engine drove the clock line");
  a_pin_data_zero: assert property (!sclOutDev && !sdaOutDev)
    else $error("pin output data not zero");
  a_oe_pulls_low: assert property (sdaOeDev |-> !sda)
    else $error("driven data line not low");
  a_change_scl_low: assert property ($changed(sdaOeDev) |-> !scl)
    else $error("data drive changed with clock high");
  a_drive_after_fall: assert property ($rose(sdaOeDev) |-> !scl && !$past(scl, 3))
    else $error("acknowledge drive too soon after clock fall");
  a_ack_spans_pulse: assert property ($rose(sdaOeDev) |-> ##[1:200] (sdaOeDev && $rose(scl)))
    else $error("acknowledge not held over a clock pulse");
  a_hold_after_fall: assert property ($fell(scl) && sdaOeDev |=> sdaOeDev [*3])
    else $error("data released too soon after clock fall");
  a_release_bound: assert property ($rose(sdaOeDev) |-> ##[1:300] !sdaOeDev)
    else $error("acknowledge drive not released");
  a_no_dev_start: assert property (scl && $fell(sda) |-> !sdaOeDev)
    else $error("engine made a start condition");
endmodule // i2c_bus_props

/* File: verif/i2c_bus_protocol_engine_test.sv */
// Self-checking bench joining the bus engine and the bus master.
`timescale 1ns/10ps
module i2c_bus_protocol_engine_test;
  import i2c_engine_pkg::*;
  logic clk, rst_n, regWr, regRd, cmdValid, cmdReady, ackSeen, evt, oePrev;
  logic [3:0] regAddr;
  logic [15:0] regWdata, regRdata, d;
  logic [1:0] cmd;
  logic [7:0] txByte, rxByte, b;
  logic [6:0] myAddr;
  logic [31:0] seed = 32'hae237ba1;
  logic [7:0] rxQ[$];
  int n_errors = 0, n_compared = 0, lowCnt = 0, holdExp = 1;
  int addressed = 0, full = 0, ovf = 0, ackVal = 0;
  i2c_bus_if bus ();
  i2c_slave_engine u_i2c_slave_engine (.clk(clk), .rst_n(rst_n), .bus(bus), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .eventIrq(evt));
  i2c_bus_master #(.HalfBit(24)) u_i2c_bus_master (.clk(clk), .rst_n(rst_n), .bus(bus), .cmd(cmd),
    .txByte(txByte), .cmdValid(cmdValid), .cmdReady(cmdReady), .rxByte(rxByte), .ackSeen(ackSeen));
  i2c_bus_props u_i2c_bus_props (.clk(clk), .rst_n(rst_n), .scl(bus.scl), .sda(bus.sda),
    .sclOeDev(bus.sclOeDev), .sdaOeDev(bus.sdaOeDev), .sclOutDev(bus.sclOutDev), .sdaOutDev(bus.sdaOutDev));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [31:0] lfsrNext(input logic [31:0] s);
    lfsrNext = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic checkReg(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic checkAck(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: ack got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic regWrite(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regWdata <= v;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic regRead(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    @(negedge clk);
    v = regRdata;
  endtask
  task automatic checkStat(input int pos, input logic exp);
    logic [15:0] s;
    regRead(RegStatAddr, s);
    checkReg({15'h0, s[pos]}, {15'h0, exp});
  endtask
  task automatic setCtrl(input logic [2:0] m, input logic hs, input logic holds, input logic ackv);
    holdExp = hs ? HoldLongCycles : HoldShortCycles;
    ackVal = holds & ackv;
    regWrite(RegCtrlAddr, {9'h000, ackv, holds, holds, hs, m, 1'b1});
  endtask
  task automatic busCmd(input logic [1:0] c, input logic [7:0] v);
    logic r;
    @(posedge clk);
    cmd <= c;
    txByte <= v;
    cmdValid <= 1'b1;
    do begin
      @(negedge clk);
      r = cmdReady;
      @(posedge clk);
    end while (r !== 1'b1);
    cmdValid <= 1'b0;
    // Wait for the master to finish, then let the engine's pin filters catch up.
    for (int i = 0; i < 5000; i++) begin
      @(negedge clk);
      if (cmdReady === 1'b1) break;
    end
    if (cmdReady !== 1'b1) begin
      n_errors++;
      tally_and_finish();
    end
    repeat (8) @(negedge clk);
    if (c != CmdByte) addressed = 0;
  endtask
  task automatic xfer(input logic [7:0] v);
    logic exp;
    exp = addressed && !full && !ovf && !ackVal;
    if (addressed && full) ovf = 1;
    else if (exp) begin
      rxQ.push_back(v);
      full = 1;
    end
    busCmd(CmdByte, v);
    checkAck(ackSeen, exp);
    checkReg({8'h0, rxByte}, {8'h0, v});
  endtask
  task automatic addrByte(input logic [6:0] a);
    addressed = (a == myAddr);
    xfer({a, 1'b0});
  endtask
  task automatic readData();
    logic [15:0] v;
    logic [7:0] e;
    e = rxQ.pop_front();
    regRead(RegDataAddr, v);
    full = 0;
    checkReg({8'h0, v[7:0]}, {8'h0, e});
  endtask
  // ****************************************
  // Clock, reset, watchdog and hold monitor
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    n_errors++;
    tally_and_finish();
  end
  always @(posedge clk) begin
    oePrev <= bus.sdaOeDev;
    lowCnt <= (bus.scl === 1'b0) ? lowCnt + 1 : 0;
    if (oePrev === 1'b1 && bus.sdaOeDev === 1'b0) checkReg({15'h0, lowCnt >= holdExp}, 16'h1);
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rst_n = 1'b0;
    {regWr, regRd, cmdValid, regAddr, regWdata, cmd, txByte} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    regRead(RegCtrlAddr, d);
    checkReg(d, {6'h0, CtrlReset});
    regWrite(4'hf, 16'hffff);
    regRead(4'hf, d);
    checkReg(d, 16'h0);
    seed = lfsrNext(seed);
    myAddr = seed[6:0];
    regWrite(RegAddrAddr, {8'h0, myAddr, 1'b0});
    setCtrl(Mode7, 1'b0, 1'b0, 1'b0);
    busCmd(CmdStart, 8'h00);
    checkStat(StStartBit, 1'b1);
    addrByte(myAddr);
    checkStat(StBufFullBit, 1'b1);
    readData();
    for (int i = 0; i < 3; i++) begin
      seed = lfsrNext(seed);
      xfer(seed[7:0]);
      readData();
    end
    seed = lfsrNext(seed);
    xfer(seed[7:0]);
    xfer(~seed[7:0]);
    checkStat(StOvfBit, 1'b1);
    readData();
    regWrite(RegStatAddr, 16'h1 << StOvfBit);
    ovf = 0;
    checkStat(StOvfBit, 1'b0);
    busCmd(CmdStop, 8'h00);
    checkStat(StStopBit, 1'b1);
    checkStat(StBusyBit, 1'b0);
    busCmd(CmdStart, 8'h00);
    addrByte(myAddr ^ 7'h01);
    setCtrl(Mode7, 1'b1, 1'b1, 1'b1);
    busCmd(CmdStart, 8'h00);
    addrByte(myAddr);
    regRead(RegDataAddr, d);
    full = 0;
    checkReg(d, {8'h0, myAddr, 1'b0});
    setCtrl(Mode7, 1'b1, 1'b1, 1'b0);
    busCmd(CmdStart, 8'h00);
    addrByte(myAddr);
    readData();
    xfer(8'h80);
    readData();
    busCmd(CmdStop, 8'h00);
    regWrite(RegStatAddr, 16'h1 << StEventBit);
    checkStat(StEventBit, 1'b0);
    checkReg({15'h0, evt}, 16'h0);
    regWrite(RegAddrAddr, 16'h0006);
    setCtrl(Mode10Irq, 1'b0, 1'b0, 1'b0);
    busCmd(CmdStart, 8'h00);
    checkReg({15'h0, evt}, 16'h1);
    addressed = 1;
    xfer(hiAddrByte(2'b11, 1'b0));
    readData();
    xfer(8'h06);
    readData();
    checkStat(StPriorBit, 1'b1);
    busCmd(CmdStop, 8'h00);
    checkStat(StPriorBit, 1'b0);
    tally_and_finish();
  end
endmodule // i2c_bus_protocol_engine_test
